// file: ets_pkg.sv
// Package for the exposure trigger sequencer: timing constants and widths.
// Assumes a 50 MHz core clock; all counts are derived from that rate.
package ets_pkg;
  localparam int          CLK_HZ          = 50000000;
  localparam int          CLK_NS          = 20;
  localparam int          TRIG_DELAY_NS   = 96000;
  localparam int          TRIG_DELAY_CYC  = TRIG_DELAY_NS / CLK_NS;
  localparam int          RISE_LAT_NS     = 10000;
  localparam int          RISE_LAT_CYC    = RISE_LAT_NS / CLK_NS;
  localparam int          FALL_LAT_NS     = 50000;
  localparam int          FALL_LAT_CYC    = FALL_LAT_NS / CLK_NS;
  localparam int          BUS_CYCLE_NS    = 125000;
  localparam int          BUS_CYCLE_CYC   = BUS_CYCLE_NS / CLK_NS;
  localparam int          RO_LINE_OVH     = 159;
  localparam int          RO_FRAME_OVH    = 4157;
  localparam longint      PIX_RATE_HZ     = 39321000;
  localparam int          CNT_W           = 40;
  localparam int          DIM_W           = 11;
  localparam logic [1:0]  TR_PORT_RST     = 2'h1;
  localparam logic [1:0]  EA_PORT_RST     = 2'h0;
  localparam int          NUM_OUT_PORTS   = 4;
  typedef enum {ST_IDLE, ST_DELAY, ST_EXPOSE, ST_READOUT} ets_state_t;
endpackage : ets_pkg

// file: ets_sequencer.sv
// Exposure trigger sequencer: edge trigger, exposure timing, readout,
// transmission start and trigger-ready / exposure-active outputs.
// Assumes trigger pin is asynchronous; configuration is static per frame.
// Functional notes
// - With continuous capture on, active trigger edges start exposures; edges in the trigger delay are dropped, edges in exposure or readout merge into one.
// - Programmable mode holds exposure exactly for the shutter setting.
// - Exposure end starts readout and transmission with no further command.
// - Exposure starts 96 us after a qualifying trigger edge.
// - Exposure-active rises a fixed delay after exposure begins.
// - Exposure-active falls a fixed delay after exposure ends.
// - Transmission starts only when the buffer is safe from over/underrun.
// - Readout lasts ((159+width)*(height+1)+4157) pixel periods.
// - Transmission time is packets needed times 125 us.
// - Start delay is 125 us, or readout minus transmission plus 125 us.
// - Trigger-ready drops when a trigger is taken, rises after readout ends.
// - No new exposure before previous readout fully finishes.
// - Trigger-ready goes to output port 1 by default, reassignable.
// - Trigger during exposure or readout is held and starts when the sequencer returns to idle.
// - Trigger-ready absent when external triggering is disabled.
// - Selectable trigger polarity; programmable and level exposure modes.
// - Polarity 0 falling, 1 rising; mode 0 programmable, 1 level.
// - Level mode exposes until the trigger returns inactive.
// - Exposure-active follows exposure; defaults to output port 0.
`timescale 1ns/1ps
module ets_sequencer
  import ets_pkg::*;
(
  input  wire logic                     mclk_in,
  input  wire logic                     nrst_in,
  input  wire logic                     external_trigger_in,
  input  wire logic                     continuous_capture_in,
  input  wire logic                     single_capture_in,
  input  wire logic                     trigger_enable_in,
  input  wire logic                     trigger_polarity_in,
  input  wire logic                     trigger_mode_in,
  input  wire logic [31:0]              shutter_cycles_in,
  input  wire logic [DIM_W-1:0]         region_width_in,
  input  wire logic [DIM_W-1:0]         region_height_in,
  input  wire logic                     sixteen_bit_in,
  input  wire logic [15:0]              bytes_per_packet_in,
  input  wire logic                     tr_port_set_in,
  input  wire logic [1:0]               tr_port_sel_in,
  input  wire logic                     ea_port_set_in,
  input  wire logic [1:0]               ea_port_sel_in,
  output logic [NUM_OUT_PORTS-1:0]      output_ports_out,
  output logic                          trigger_ready_out,
  output logic                          exposure_active_out,
  output logic                          exposing_out,
  output logic                          readout_active_out,
  output logic                          transmit_start_out,
  output logic                          single_done_out
);

  ets_state_t        state;
  logic              trig_s1;
  logic              trig_s2;
  logic              trig_d;
  logic              pending;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  tx_cnt;
  logic              tx_wait;
  logic [15:0]       rise_cnt;
  logic [15:0]       fall_cnt;
  logic              rise_go;
  logic              fall_go;
  logic [1:0]        tr_port;
  logic [1:0]        ea_port;
  logic              ready_int;
  logic              single_armed;

  // Edge detect and arming decode.
  // The edge detector works on the second synchroniser stage only, so a
  // pin that changes near a clock edge cannot give two different answers
  // to the decode below. Edges are taken only when capture is armed and
  // external triggering is on; anything else is dropped on the floor and
  // neither starts an exposure nor disturbs trigger-ready.
  // The level decode is used by level-controlled exposure to find its end.
  wire rise_edge   = trig_s2 & ~trig_d;
  wire fall_edge   = ~trig_s2 & trig_d;
  wire active_edge = trigger_polarity_in ? rise_edge : fall_edge;
  wire level_inact = trigger_polarity_in ? ~trig_s2 : trig_s2;
  wire armed       = continuous_capture_in | single_armed;
  wire take_edge   = active_edge & armed & trigger_enable_in;
  wire idle_ready  = (state == ST_IDLE);

  // Readout length in core cycles from pixel periods.
  // All frame arithmetic is done at the full counter width, so that a
  // full-size region cannot wrap the pixel or byte counts.
  // The pixel period count is scaled to core cycles by integer division,
  // which rounds down; readout may be up to one core cycle short.
  // The packet count rounds up, as a partly filled packet still takes a
  // whole bus cycle. A packet size of zero is read as one byte.
  // The start delay keeps the frame buffer from over- or underrunning.
  wire [CNT_W-1:0] ro_pix = CNT_W'((RO_LINE_OVH + region_width_in) *
                      (region_height_in + 1) + RO_FRAME_OVH);
  wire [CNT_W-1:0] ro_cyc = CNT_W'((64'(ro_pix) * CLK_HZ) / PIX_RATE_HZ);
  wire [CNT_W-1:0] bytes  = (CNT_W'(region_width_in) *
                      CNT_W'(region_height_in)) <<
                      (sixteen_bit_in ? 1 : 0);
  wire [15:0]      bpp    = (bytes_per_packet_in == 16'h0) ? 16'h1
                      : bytes_per_packet_in;
  wire [CNT_W-1:0] pkts   = (bytes + CNT_W'(bpp) - 1) / CNT_W'(bpp);
  wire [CNT_W-1:0] tx_cyc = CNT_W'(pkts * BUS_CYCLE_CYC);
  wire [CNT_W-1:0] st_cyc = (tx_cyc > ro_cyc) ? CNT_W'(BUS_CYCLE_CYC)
                      : CNT_W'(ro_cyc - tx_cyc + BUS_CYCLE_CYC);

  // Trigger synchroniser.
  // The pin is asynchronous to the core clock, so two flip-flops settle it
  // before any logic reads it. The third stage only delays the settled
  // value for the edge detector.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_d  <= 1'b0;
    end else begin
      trig_s1 <= external_trigger_in;
      trig_s2 <= trig_s1;
      trig_d  <= trig_s2;
    end
  end

  // Single-capture arming, cleared once its frame is under way.
  // A new arming request in the same cycle as the clear wins, but the clear repeats in
  // every trigger-delay cycle, so a request that races the start of a frame is cleared.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      single_armed <= 1'b0;
    end else if (single_capture_in) begin
      single_armed <= 1'b1;
    end else if (state == ST_DELAY) begin
      single_armed <= 1'b0;
    end
  end

  // Main exposure / readout sequencer.
  // One counter serves all timed states: the trigger delay, the programmed
  // exposure and the readout. Edges during exposure or readout are held as
  // one pending request and start the next frame when the sequencer comes
  // back to idle, so a held frame is not lost and no exposure overlaps a readout.
  // Edges during the trigger delay are dropped: ready is already low then.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state   <= ST_IDLE;
      cnt     <= '0;
      pending <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take_edge | pending) begin
            state   <= ST_DELAY;
            pending <= 1'b0;
            cnt     <= CNT_W'(TRIG_DELAY_CYC - 1);
          end
        end
        ST_DELAY: begin
          if (cnt == '0) begin
            state <= ST_EXPOSE;
            cnt   <= CNT_W'(shutter_cycles_in == 32'h0 ? 32'h0
                     : shutter_cycles_in - 32'h1);
          end else begin
            cnt <= cnt - CNT_W'(1);
          end
        end
        ST_EXPOSE: begin
          if (take_edge) pending <= 1'b1;
          if (trigger_mode_in ? level_inact : (cnt == '0)) begin
            state <= ST_READOUT;
            cnt   <= (ro_cyc == '0) ? '0 : ro_cyc - CNT_W'(1);
          end else if (!trigger_mode_in) begin
            cnt <= cnt - CNT_W'(1);
          end
        end
        ST_READOUT: begin
          if (take_edge) pending <= 1'b1;
          if (cnt == '0) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - CNT_W'(1);
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Transmission start timer from readout start.
  // The timer is loaded in the same cycle in which the sequencer enters
  // readout, so its count runs from the first readout cycle. It has its own
  // counter, as the start delay may outlast the readout of the frame.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_wait            <= 1'b0;
      tx_cnt             <= '0;
      transmit_start_out <= 1'b0;
    end else begin
      transmit_start_out <= 1'b0;
      if (state == ST_EXPOSE && (trigger_mode_in ? level_inact
          : cnt == '0)) begin
        tx_wait <= 1'b1;
        tx_cnt  <= st_cyc - CNT_W'(1);
      end else if (tx_wait) begin
        if (tx_cnt == '0) begin
          tx_wait            <= 1'b0;
          transmit_start_out <= 1'b1;
        end else begin
          tx_cnt <= tx_cnt - CNT_W'(1);
        end
      end
    end
  end

  // Exposure-active output with fixed rise and fall latencies.
  // Both latencies are package constants, so every exposure on a unit sees
  // the same delays. A very short exposure may end before the rise delay
  // has run out; the fall timer is the later one and so clears the output.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rise_go             <= 1'b0;
      fall_go             <= 1'b0;
      rise_cnt            <= '0;
      fall_cnt            <= '0;
      exposure_active_out <= 1'b0;
    end else begin
      if (state == ST_DELAY && cnt == '0) begin
        rise_go  <= 1'b1;
        rise_cnt <= 16'(RISE_LAT_CYC - 1);
      end else if (rise_go) begin
        if (rise_cnt == 16'h0) begin
          rise_go             <= 1'b0;
          exposure_active_out <= 1'b1;
        end else begin
          rise_cnt <= rise_cnt - 16'h1;
        end
      end
      if (state == ST_EXPOSE && state != ST_DELAY &&
          (trigger_mode_in ? level_inact : cnt == '0)) begin
        fall_go  <= 1'b1;
        fall_cnt <= 16'(FALL_LAT_CYC - 1);
      end else if (fall_go) begin
        if (fall_cnt == 16'h0) begin
          fall_go             <= 1'b0;
          exposure_active_out <= 1'b0;
        end else begin
          fall_cnt <= fall_cnt - 16'h1;
        end
      end
    end
  end

  // Port assignment and registered outputs.
  // Port selections take effect on the cycle after their set strobe, and
  // every output leaves the block straight from a flip-flop.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tr_port            <= TR_PORT_RST;
      ea_port            <= EA_PORT_RST;
      trigger_ready_out  <= 1'b0;
      exposing_out       <= 1'b0;
      readout_active_out <= 1'b0;
      single_done_out    <= 1'b0;
    end else begin
      if (tr_port_set_in) tr_port <= tr_port_sel_in;
      if (ea_port_set_in) ea_port <= ea_port_sel_in;
      trigger_ready_out  <= ready_int;
      exposing_out       <= (state == ST_EXPOSE);
      readout_active_out <= (state == ST_READOUT);
      single_done_out    <= transmit_start_out & ~continuous_capture_in;
    end
  end

  // Ready is low from trigger through readout, absent if triggering off.
  // A held request also keeps ready low, as its frame is already committed.
  assign ready_int = idle_ready & ~pending & trigger_enable_in;

  // Per-port routing of the two output signals.
  // Both signals may share one port; the port then shows their logical or.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT_PORTS; gi++) begin : g_port
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          output_ports_out[gi] <= 1'b0;
        end else begin
          output_ports_out[gi] <= (tr_port == 2'(gi) && ready_int) |
                                  (ea_port == 2'(gi) && exposure_active_out);
        end
      end
    end
  endgenerate

endmodule : ets_sequencer

// file: ets_properties.sv
// Checker for the exposure trigger sequencer output timing.
// Assumes it is bound to ets_sequencer and sees only its ports.
`timescale 1ns/1ps
module ets_properties
  import ets_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic external_trigger_in,
  input wire logic continuous_capture_in,
  input wire logic trigger_enable_in,
  input wire logic trigger_polarity_in,
  input wire logic trigger_ready_out,
  input wire logic exposure_active_out,
  input wire logic exposing_out,
  input wire logic readout_active_out,
  input wire logic transmit_start_out
);
  localparam int TD0 = TRIG_DELAY_CYC - 1;
  localparam int TD1 = TRIG_DELAY_CYC + 8;
  localparam int RL0 = RISE_LAT_CYC - 1;
  localparam int RL1 = RISE_LAT_CYC + 1;
  localparam int FL0 = FALL_LAT_CYC - 1;
  localparam int FL1 = FALL_LAT_CYC + 1;
  localparam int BC0 = BUS_CYCLE_CYC - 2;
  int   ct, cx, cf, cr;
  logic q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  // Counts cycles since each cause; q marks a trigger accepted while ready.
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ct <= 0;
      cx <= 0;
      cf <= 0;
      cr <= 0;
      q  <= 1'b0;
    end else begin
      ct <= q ? ct + 1 : 0;
      cx <= $rose(exposing_out) ? 1 : cx + 1;
      cf <= $fell(exposing_out) ? 1 : cf + 1;
      cr <= $rose(readout_active_out) ? 1 : cr + 1;
      if ((trigger_polarity_in ? $rose(external_trigger_in)
           : $fell(external_trigger_in)) && continuous_capture_in
          && trigger_enable_in && trigger_ready_out) q <= 1'b1;
      else if ($rose(exposing_out)) q <= 1'b0;
    end
  end
  // Each timing property ties an output moment to its cause with a fixed figure; the three ready properties check levels only.
  sequence s_exp_end; $fell(exposing_out); endsequence
  property p_trig; q |-> ct <= TD1 && (!$rose(exposing_out) || ct >= TD0);
  endproperty
  property p_rise; $rose(exposure_active_out) |-> cx >= RL0 && cx <= RL1;
  endproperty
  property p_fall; $fell(exposure_active_out) |-> cf >= FL0 && cf <= FL1;
  endproperty
  property p_rdy_low; $rose(exposing_out) |-> !trigger_ready_out; endproperty
  property p_rdy_up;
    $rose(trigger_ready_out) |-> !exposing_out && !readout_active_out;
  endproperty
  property p_ro; s_exp_end |-> ##[0:2] readout_active_out; endproperty
  property p_off; !trigger_enable_in [*2] |-> !trigger_ready_out; endproperty
  property p_tx; transmit_start_out |-> cr >= BC0; endproperty
  a_trig: assert property (p_trig)
    else $error("exposure start delay off");
  a_rise: assert property (p_rise)
    else $error("active rise latency off");
  a_fall: assert property (p_fall)
    else $error("active fall latency off");
  a_rdy_low: assert property (p_rdy_low)
    else $error("ready high at exposure start");
  a_rdy_up: assert property (p_rdy_up)
    else $error("ready rose while busy");
  a_ro: assert property (p_ro)
    else $error("no readout after exposure");
  a_off: assert property (p_off)
    else $error("ready shown with triggering off");
  a_tx: assert property (p_tx)
    else $error("transmission started too early");
endmodule : ets_properties
bind ets_sequencer ets_properties ets_properties_i (.mclk_in, .nrst_in,
  .external_trigger_in, .continuous_capture_in, .trigger_enable_in,
  .trigger_polarity_in, .trigger_ready_out, .exposure_active_out,
  .exposing_out, .readout_active_out, .transmit_start_out);

// file: ets_trigger_source.sv
// Model of the external trigger source that watches trigger-ready.
// Assumes the bench pulses go_in for one cycle per wanted edge.
`timescale 1ns/1ps
module ets_trigger_source (
  input  wire logic        mclk_in,
  input  wire logic        ready_in,
  input  wire logic        pol_in,
  input  wire logic        early_in,
  input  wire logic        go_in,
  input  wire logic [15:0] hold_in,
  output logic             trig_out = 1'b0
);
  // Rests at the inactive level; early_in fires without waiting for ready.
  always @(posedge mclk_in) begin
    if (go_in) begin
      for (int n = 0; n < 20000 && !ready_in && !early_in; n++)
        @(posedge mclk_in);
      trig_out <= pol_in;
      repeat (hold_in) @(posedge mclk_in);
    end
    trig_out <= !pol_in;
  end
endmodule : ets_trigger_source

// file: tb_exposure_trigger_sequencer.sv
// Self-checking bench: frame timings against an integer model.
// Assumes ets_pkg, the sequencer, checker and source model compile first.
`timescale 1ns/1ps
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_exposure_trigger_sequencer;
  import ets_pkg::*;
  logic mclk_in = 1'b0, nrst = 1'b0, cc = 1'b0, sc = 1'b0, en = 1'b1;
  logic pol = 1'b1, md = 1'b0, sb = 1'b0, go = 1'b0, ea = 1'b0, tps = 1'b0;
  logic [31:0]      shut = 32'h40;
  logic [DIM_W-1:0] w = 'h4, h = 'h2;
  logic [15:0]      pk = 16'h8, hold = 16'h3c;
  logic [1:0]       tsel = 2'h1;
  logic [3:0]       ports;
  logic             trig, rdy, expo, ro, txs, sdone;
  int errors, total_checks, last, ro_x, st_x, elen, rlen, slen, n, sd_n;
  int exp_q[$];
  always #10 mclk_in = ~mclk_in;
  ets_sequencer ets_sequencer_i (.mclk_in, .nrst_in(nrst),
    .external_trigger_in(trig), .continuous_capture_in(cc),
    .single_capture_in(sc), .trigger_enable_in(en),
    .trigger_polarity_in(pol), .trigger_mode_in(md), .shutter_cycles_in(shut),
    .region_width_in(w), .region_height_in(h), .sixteen_bit_in(sb),
    .bytes_per_packet_in(pk), .tr_port_set_in(tps), .tr_port_sel_in(tsel),
    .ea_port_set_in(1'b0), .ea_port_sel_in(2'h0), .output_ports_out(ports),
    .trigger_ready_out(rdy), .exposure_active_out(), .exposing_out(expo),
    .readout_active_out(ro), .transmit_start_out(txs),
    .single_done_out(sdone));
  ets_trigger_source ets_trigger_source_i (.mclk_in, .ready_in(rdy),
    .pol_in(pol), .early_in(ea), .go_in(go), .hold_in(hold), .trig_out(trig));
  function automatic int snap(int a, int b, int t);
    return (a >= b - t && a <= b + t) ? b : a;
  endfunction : snap
  // Measures exposure, readout and transmit start against the model.
  always @(posedge mclk_in) begin
    slen = (ro && rlen == 0) ? 0 : slen + 1;
    if (sdone) sd_n++;
    if (expo) elen++;
    else if (elen > 0) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) `CHK(snap(elen, exp_q[0], md ? 8 : 0), exp_q[0])
      if (exp_q.size() > 0) exp_q.delete(0);
      elen = 0;
    end
    if (ro) rlen++;
    else if (rlen > 0) begin
      `CHK(snap(rlen, ro_x, 2), ro_x)
      rlen = 0;
    end
    if (txs) `CHK(snap(slen, st_x, 2), st_x)
  end
  task automatic test_done;
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // Random frame setup; model of readout and transmission start.
  task automatic cfg;
    int wv, hv, bv, pv, sv, tx;
    wv = 4 * (1 + $urandom % 4);
    hv = 1 + $urandom % 16;
    bv = $urandom % 2;
    pv = ($urandom % 2) ? 8 : 2048;
    sv = 20 + $urandom % 480;
    {w, h, sb, pk, shut} <= {wv[10:0], hv[10:0], bv[0], pv[15:0], sv};
    ro_x = $rtoi(((RO_LINE_OVH + wv) * (hv + 1) + RO_FRAME_OVH)
                 * 1.0 * CLK_HZ / PIX_RATE_HZ);
    tx = ((wv * hv * (bv + 1) + pv - 1) / pv) * BUS_CYCLE_CYC;
    st_x = tx > ro_x ? BUS_CYCLE_CYC : ro_x - tx + BUS_CYCLE_CYC;
    last = md ? int'(hold) - TRIG_DELAY_CYC : sv;
  endtask : cfg
  task automatic shot(input bit e, input bit x);
    if (!e) cfg;
    if (x) exp_q.push_back(last);
    {go, ea} <= {1'b1, e};
    @(posedge mclk_in);
    go <= 1'b0;
  endtask : shot
  task automatic idle(input int c);
    for (n = 0; n < c && (exp_q.size() || !rdy || ro); n++) @(posedge mclk_in);
    if (n == c && c > 9000) begin
      errors++;
      test_done;
    end
  endtask : idle
  initial begin
    void'($urandom(32'hf506));
    repeat (12) @(posedge mclk_in);
    nrst <= 1'b1;
    cc <= 1'b1;
    idle(10);
    `CHK(ports[1:0], 2'b10)
    shot(0, 1);
    for (n = 0; n < 20000 && !ro; n++) @(posedge mclk_in);
    if (n == 20000) begin
      errors++;
      test_done;
    end
    shot(1, 1);
    idle(40000);
    cc <= 1'b0;
    shot(1, 0);
    repeat (6000) @(posedge mclk_in);
    {pol, md, hold, sc} <= {1'b0, 1'b1, 16'h1770, 1'b1};
    @(posedge mclk_in);
    sc <= 1'b0;
    shot(0, 1);
    idle(40000);
    {pol, md, hold, en, cc} <= {1'b1, 1'b0, 16'h3c, 1'b0, 1'b1};
    repeat (3) @(posedge mclk_in);
    shot(1, 0);
    repeat (6000) @(posedge mclk_in);
    `CHK(rdy, 1'b0)
    {en, tsel, tps} <= {1'b1, 2'h2, 1'b1};
    @(posedge mclk_in);
    tps <= 1'b0;
    shot(0, 1);
    idle(40000);
    repeat (3) @(posedge mclk_in);
    `CHK(ports[2], 1'b1)
    `CHK(sd_n, 1)
    test_done;
  end
endmodule : tb_exposure_trigger_sequencer
